// >>> rtl/timer_regs_pkg.sv
// constants and types for the timer reload and capture/compare register block
package timer_regs_pkg;
   localparam logic [7:0] OFS_COUNTER = 8'h24;
   localparam logic [7:0] OFS_RELOAD = 8'h2C;
   localparam logic [7:0] OFS_CH0 = 8'h34;
   localparam logic [7:0] OFS_CH1 = 8'h38;
   localparam logic [7:0] OFS_CH2 = 8'h3C;
   localparam logic [7:0] OFS_CFG = 8'hFC;
   localparam int SUPPRESS_BIT = 1;
   localparam int NUM_CH = 3;
   localparam logic [15:0] VALUE_RESET = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [2:0] input_mode;
      logic [2:0] shadow_en;
      logic [2:0] capture;
      logic update;
   } chan_ctrl_s;

   typedef struct packed {
      logic [15:0] counter;
      logic counter_load;
   } counter_load_s;
endpackage

// >>> rtl/timer_reload_compare_regs.sv
// AXI4-Lite register block: reload limit, channel 0..2 capture/compare values, write filter
module timer_reload_compare_regs (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic [15:0] COUNTER_VALUE,
   input wire timer_regs_pkg::chan_ctrl_s CHAN_CTRL,
   output timer_regs_pkg::counter_load_s COUNTER_LOAD,
   output logic [15:0] RELOAD_LIMIT,
   output logic [47:0] COMPARE_ACTIVE
);
   import timer_regs_pkg::*;

   // ---------------------------------------------------------------
   // write channel capture
   // ---------------------------------------------------------------
   logic aw_held, w_held, next_aw_held, next_w_held;
   logic [7:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic bvalid, next_bvalid;
   logic [1:0] bresp, next_bresp;
   logic [15:0] reload_limit, next_reload_limit;
   logic same_value_write_suppress, next_same_value_write_suppress;
   logic [15:0] channel_value [NUM_CH];
   logic [15:0] next_channel_value [NUM_CH];
   logic [15:0] compare_active [NUM_CH];
   logic [15:0] next_compare_active [NUM_CH];
   counter_load_s counter_load, next_counter_load;
   logic do_write;

   function automatic logic [1:0] chan_index(input logic [7:0] a);
      if (a == OFS_CH0) begin
         return 2'd0;
      end else if (a == OFS_CH1) begin
         return 2'd1;
      end else if (a == OFS_CH2) begin
         return 2'd2;
      end else begin
         return 2'd3;
      end
   endfunction

   assign do_write = aw_held && w_held && !bvalid;

   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_reload_limit = reload_limit;
      next_same_value_write_suppress = same_value_write_suppress;
      next_counter_load = '0;
      if (AWVALID && !aw_held) begin
         next_aw_held = 1'b1;
         next_aw_addr = AWADDR;
      end
      if (WVALID && !w_held) begin
         next_w_held = 1'b1;
         next_w_data = WDATA;
         next_w_strb = WSTRB;
      end
      if (bvalid && BREADY) begin
         next_bvalid = 1'b0;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = RESP_OKAY;
         if (w_strb != 4'hF) begin
            next_bresp = RESP_SLVERR;
         end else if (aw_addr == OFS_RELOAD) begin
            next_reload_limit = w_data[15:0];
         end else if (aw_addr == OFS_CFG) begin
            next_same_value_write_suppress = w_data[SUPPRESS_BIT];
         end else if (aw_addr == OFS_COUNTER) begin
            next_counter_load.counter = w_data[15:0];
            next_counter_load.counter_load = 1'b1;
         end else if (chan_index(aw_addr) == 2'd3) begin
            next_bresp = RESP_SLVERR;
         end
      end
   end

   // ---------------------------------------------------------------
   // channel values, capture and shadow
   // ---------------------------------------------------------------
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      logic wr_hit;
      assign wr_hit = do_write && (w_strb == 4'hF) && (chan_index(aw_addr) == 2'(i));
      always_comb begin
         next_channel_value[i] = channel_value[i];
         if (CHAN_CTRL.input_mode[i]) begin
            if (CHAN_CTRL.capture[i]) begin
               next_channel_value[i] = COUNTER_VALUE;
            end
         end else if (wr_hit) begin
            if (!(same_value_write_suppress && w_data[15:0] == channel_value[i])) begin
               next_channel_value[i] = w_data[15:0];
            end
         end
         next_compare_active[i] = compare_active[i];
         if (!CHAN_CTRL.shadow_en[i] || CHAN_CTRL.update) begin
            next_compare_active[i] = next_channel_value[i];
         end
      end
      always_ff @(posedge CLK) begin
         if (SRST) begin
            channel_value[i] <= VALUE_RESET;
            compare_active[i] <= VALUE_RESET;
         end else begin
            channel_value[i] <= next_channel_value[i];
            compare_active[i] <= next_compare_active[i];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         reload_limit <= VALUE_RESET;
         same_value_write_suppress <= 1'b0;
         counter_load <= '0;
         COMPARE_ACTIVE <= '0;
         // ready ports come from flops that hold the inverse of the held flags, not from an inverter
         AWREADY <= 1'b1;
         WREADY <= 1'b1;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         reload_limit <= next_reload_limit;
         same_value_write_suppress <= next_same_value_write_suppress;
         counter_load <= next_counter_load;
         COMPARE_ACTIVE <= {next_compare_active[2], next_compare_active[1],
                            next_compare_active[0]};
         AWREADY <= !next_aw_held;
         WREADY <= !next_w_held;
      end
   end

   assign BVALID = bvalid;
   assign BRESP = bresp;
   assign RELOAD_LIMIT = reload_limit;
   assign COUNTER_LOAD = counter_load;

   // ---------------------------------------------------------------
   // read channel
   // ---------------------------------------------------------------
   logic rvalid, next_rvalid;
   logic [31:0] rdata, next_rdata;
   logic [1:0] rresp, next_rresp;

   always_comb begin
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (rvalid && RREADY) begin
         next_rvalid = 1'b0;
      end
      if (ARVALID && !rvalid) begin
         next_rvalid = 1'b1;
         next_rresp = RESP_OKAY;
         next_rdata = '0;
         if (ARADDR == OFS_RELOAD) begin
            next_rdata = {16'h0000, reload_limit};
         end else if (ARADDR == OFS_CFG) begin
            next_rdata[SUPPRESS_BIT] = same_value_write_suppress;
         end else if (ARADDR == OFS_COUNTER) begin
            next_rdata = {16'h0000, COUNTER_VALUE};
         end else if (chan_index(ARADDR) != 2'd3) begin
            next_rdata = {16'h0000, channel_value[chan_index(ARADDR)]};
         end else begin
            next_rresp = RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
         ARREADY <= 1'b1;
      end else begin
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
         ARREADY <= !next_rvalid;
      end
   end

   assign RVALID = rvalid;
   assign RDATA = rdata;
   assign RRESP = rresp;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_reload_write: assert property (@(posedge CLK) disable iff (SRST)
      do_write && w_strb == 4'hF && aw_addr == OFS_RELOAD |=> RELOAD_LIMIT == $past(w_data[15:0]))
      else $error("reload write not stored");
   a_input_hold: assert property (@(posedge CLK) disable iff (SRST)
      CHAN_CTRL.input_mode[0] && !CHAN_CTRL.capture[0] |=> $stable(channel_value[0]))
      else $error("input channel changed without capture");
   a_capture_take: assert property (@(posedge CLK) disable iff (SRST)
      CHAN_CTRL.input_mode[1] && CHAN_CTRL.capture[1] |=> channel_value[1] == $past(COUNTER_VALUE))
      else $error("capture not taken");
   a_output_write: assert property (@(posedge CLK) disable iff (SRST)
      g_ch[2].wr_hit && !CHAN_CTRL.input_mode[2] && !same_value_write_suppress
      |=> channel_value[2] == $past(w_data[15:0]))
      else $error("output channel write lost");
   a_shadow_hold: assert property (@(posedge CLK) disable iff (SRST)
      CHAN_CTRL.shadow_en[0] && !CHAN_CTRL.update |=> $stable(COMPARE_ACTIVE[15:0]))
      else $error("shadow moved without update");
   a_suppress_eq: assert property (@(posedge CLK) disable iff (SRST)
      g_ch[0].wr_hit && same_value_write_suppress && !CHAN_CTRL.input_mode[0]
      && w_data[15:0] == channel_value[0]
      |=> channel_value[0] == $past(channel_value[0]))
      else $error("suppressed write altered value");
   a_cfg_only_sw: assert property (@(posedge CLK) disable iff (SRST)
      !(do_write && aw_addr == OFS_CFG) |=> $stable(same_value_write_suppress))
      else $error("suppress bit changed without write");
   a_counter_pulse: assert property (@(posedge CLK) disable iff (SRST)
      COUNTER_LOAD.counter_load |=> !COUNTER_LOAD.counter_load)
      else $error("counter load not a pulse");
   a_bresp_time: assert property (@(posedge CLK) disable iff (SRST)
      do_write |=> BVALID)
      else $error("write response missing");
   c_capture: cover property (@(posedge CLK) CHAN_CTRL.input_mode[0] && CHAN_CTRL.capture[0]);
   c_suppress: cover property (@(posedge CLK) g_ch[1].wr_hit && same_value_write_suppress);
   c_update: cover property (@(posedge CLK) CHAN_CTRL.shadow_en[2] && CHAN_CTRL.update);
endmodule

// >>> verif/tb.sv
// self-checking bench for the timer reload and capture/compare register block
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import timer_regs_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   logic [15:0] counter_value = 16'h0, reload_limit, last_load, m_reload;
   logic [47:0] compare_active;
   chan_ctrl_s chan_ctrl = '0;
   counter_load_s counter_load;
   int mismatches = 0, checks = 0, cycles = 0, loads = 0;
   logic [31:0] seed = 32'h04169685;
   logic [15:0] m_ch [3];
   logic [7:0] regs [5] = '{OFS_RELOAD, OFS_CH0, OFS_CH1, OFS_CH2, OFS_CFG};

   always #50 clk = ~clk;

   timer_reload_compare_regs dut_u (.CLK(clk), .SRST(srst), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
      .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
      .COUNTER_VALUE(counter_value), .CHAN_CTRL(chan_ctrl), .COUNTER_LOAD(counter_load),
      .RELOAD_LIMIT(reload_limit), .COMPARE_ACTIVE(compare_active));

   function logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction

   task cmp_val(input logic [47:0] got, input logic [47:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: value %h expected %h", $time, got, exp);
      end
   endtask

   task cmp_resp(input logic [1:0] got, input logic [1:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: response %h expected %h", $time, got, exp);
      end
   endtask

   task end_of_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // -------------------------------------------
   // bus cycles
   // -------------------------------------------
   task axi_write(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                  output logic [1:0] resp);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clk);
         if (!aw_done && awready === 1'b1) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready === 1'b1) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask

   task axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      v = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   // one-cycle pulse on chosen control bits, then one edge for the result to land
   task strobe(input logic [9:0] mask);
      @(posedge clk);
      chan_ctrl <= chan_ctrl | mask;
      @(posedge clk);
      chan_ctrl <= chan_ctrl & ~mask;
      @(posedge clk);
   endtask

   always @(posedge clk) begin
      cycles++;
      if (counter_load.counter_load === 1'b1) begin
         loads++;
         last_load = counter_load.counter;
      end
      if (cycles == 20000) begin
         mismatches++;
         end_of_test();
      end
   end

   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         axi_read(regs[i], d, r);
         cmp_val(d, 0);
      end
      m_reload = rnd();
      axi_write(OFS_RELOAD, {16'h0, m_reload}, 4'hF, r);
      axi_read(OFS_RELOAD, d, r);
      cmp_val(d, {16'h0, m_reload});
      cmp_val(reload_limit, m_reload);
      for (int i = 0; i < NUM_CH; i++) begin
         m_ch[i] = rnd();
         axi_write(OFS_CH0 + 8'(4 * i), {16'h0, m_ch[i]}, 4'hF, r);
         cmp_val(compare_active[16*i +: 16], m_ch[i]);
         chan_ctrl.shadow_en[i] <= 1'b1;
         d = {16'h0, rnd()};
         axi_write(OFS_CH0 + 8'(4 * i), d, 4'hF, r);
         cmp_val(compare_active[16*i +: 16], m_ch[i]);
         strobe(10'h001);
         m_ch[i] = d[15:0];
         cmp_val(compare_active[16*i +: 16], m_ch[i]);
         chan_ctrl.shadow_en[i] <= 1'b0;
         chan_ctrl.input_mode[i] <= 1'b1;
         axi_write(OFS_CH0 + 8'(4 * i), {16'h0, ~m_ch[i]}, 4'hF, r);
         cmp_resp(r, RESP_OKAY);
         axi_read(OFS_CH0 + 8'(4 * i), d, r);
         cmp_val(d, m_ch[i]);
         m_ch[i] = rnd();
         counter_value <= m_ch[i];
         strobe(10'h002 << i);
         axi_read(OFS_CH0 + 8'(4 * i), d, r);
         cmp_val(d, m_ch[i]);
         chan_ctrl.input_mode[i] <= 1'b0;
      end
      axi_write(OFS_CFG, 32'(1 << SUPPRESS_BIT), 4'hF, r);
      axi_read(OFS_CFG, d, r);
      cmp_val(d, 32'(1 << SUPPRESS_BIT));
      for (int i = 0; i < NUM_CH; i++) begin
         axi_write(OFS_CH0 + 8'(4 * i), {16'h0, m_ch[i]}, 4'hF, r);
         cmp_resp(r, RESP_OKAY);
         axi_read(OFS_CH0 + 8'(4 * i), d, r);
         cmp_val(d, m_ch[i]);
         m_ch[i] = m_ch[i] ^ 16'h8000;
         axi_write(OFS_CH0 + 8'(4 * i), {16'h0, m_ch[i]}, 4'hF, r);
         axi_read(OFS_CH0 + 8'(4 * i), d, r);
         cmp_val(d, m_ch[i]);
      end
      axi_write(OFS_CFG, 32'h0, 4'hF, r);
      axi_read(OFS_CFG, d, r);
      cmp_val(d, 0);
      // refused accesses answer SLVERR and leave the reload register untouched, then one counter load is checked
      axi_write(8'h80, 32'h1234, 4'hF, r);
      cmp_resp(r, RESP_SLVERR);
      axi_read(8'h80, d, r);
      cmp_resp(r, RESP_SLVERR);
      axi_write(OFS_RELOAD, {16'h0, ~m_reload}, 4'h3, r);
      cmp_resp(r, RESP_SLVERR);
      axi_read(OFS_RELOAD, d, r);
      cmp_val(d, {16'h0, m_reload});
      d = {16'h0, rnd()};
      axi_write(OFS_COUNTER, d, 4'hF, r);
      repeat (2) @(posedge clk);
      cmp_val(loads, 1);
      cmp_val(last_load, d[15:0]);
      axi_read(OFS_COUNTER, d, r);
      cmp_val(d, {16'h0, counter_value});
      end_of_test();
   end
endmodule
